//--- verilog/spi_front_cfg.svh
// Constants for the serial register-access front end: command layout, index walk, role and register masks, FIFO shape
`ifndef SPI_FRONT_CFG_SVH
`define SPI_FRONT_CFG_SVH

// Command byte fields
`define CMD_IDX_HI       7
`define CMD_IDX_LO       3
`define CMD_ZERO_BIT     2
`define CMD_DIR_BIT      1
`define CMD_ACK_BIT      0
`define DIR_READ         1'h0
`define DIR_WRITE        1'h1

// Index walk boundaries
`define IDX_FIFO_LAST    5'h04
`define IDX_INC_A_LAST   5'h13
`define IDX_FROZEN_MID   5'h14
`define IDX_LAST         5'h1F

// Role configuration register and its host bit
`define ROLE_REG_IDX     5'h1B
`define ROLE_HOST_BIT    0
`define ROLE_HOST_RESET  1'h0

// Registers reachable in each mode, one bit per index (26 and 23 set bits)
`define PERIPH_REG_MASK  32'h09FF_FFFF
`define HOST_REG_MASK    32'hFFFF_C01F

// Word layout and FIFO shape
`define BYTE_W           8
`define IDX_W            5
`define FIFO_DEPTH       8
`define BIT_LAST         3'h7

`endif

//--- verilog/spi_front_pkg.sv
// Types shared by the serial front end and its self-checking bench
`include "spi_front_cfg.svh"
package spi_front_pkg;

	// Transfer phase, Gray coded along idle -> command -> data
	typedef enum logic [1:0] {
		PHASE_IDLE = 2'h0,
		PHASE_CMD  = 2'h1,
		PHASE_DATA = 2'h3
	} phase_t;

	// One register write travelling to the register file
	typedef struct packed {
		logic [`IDX_W-1:0]  index;
		logic [`BYTE_W-1:0] data;
	} wr_word_t;

	// Whole state of the front end
	typedef struct packed {
		logic               ss_s1;
		logic               ss_s2;
		logic               ss_s3;
		logic               sclk_s1;
		logic               sclk_s2;
		logic               sclk_s3;
		logic               mosi_s1;
		logic               mosi_s2;
		phase_t             phase;
		logic [2:0]         bit_cnt;
		logic               dir;
		logic [`IDX_W-1:0]  index;
		logic [`BYTE_W-1:0] rx;
		logic [`BYTE_W-1:0] tx;
		logic               hold;
		logic               host;
		logic               ack_set;
		logic               miso;
		logic               miso_oe;
		logic               mosi_out;
		logic               mosi_oe;
		logic               rd_req;
		logic [`IDX_W-1:0]  rd_index;
		logic               push;
		wr_word_t           push_word;
		logic               overrun;
	} front_state_t;

endpackage : spi_front_pkg

//--- verilog/wr_fifo.sv
// Write FIFO between the serial front end and the register file
module wr_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);

	// Head always sits in slot 0 so the outputs come straight from flops
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [CW-1:0]               count;
		logic                        has_data;
		logic                        has_room;
	} fifo_state_t;

	fifo_state_t st;
	fifo_state_t next_st;
	logic        do_push;
	logic        do_pop;

	assign do_push   = in_valid && st.has_room;
	assign do_pop    = out_ready && st.has_data;
	assign in_ready  = st.has_room;
	assign out_valid = st.has_data;
	assign out_data  = st.mem[0];

	// Shift down on pop, write at the fill level on push
	always_comb begin
		logic [CW-1:0] wr_slot;
		next_st = st;
		wr_slot = st.count;
		if (do_pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_st.mem[i] = st.mem[i + 1];
			end
			wr_slot = st.count - CW'(1);
		end
		if (do_push) begin
			next_st.mem[wr_slot] = in_data;
		end
		next_st.count    = st.count + CW'(do_push) - CW'(do_pop);
		next_st.has_data = (next_st.count != '0);
		next_st.has_room = (next_st.count != CW'(DEPTH));
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st <= '0;
			st.has_room <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	a_fifo_bound : assert property (@(posedge mclk) disable iff (srst)
		st.count <= CW'(DEPTH)) else $error("fifo count beyond depth");
	a_fifo_flags : assert property (@(posedge mclk) disable iff (srst)
		(st.has_data == (st.count != '0)) && (st.has_room == (st.count != CW'(DEPTH))))
		else $error("fifo flags disagree with count");

endmodule : wr_fifo

//--- verilog/spi_front.sv
// Serial slave front end that reads and writes the register file
`include "spi_front_cfg.svh"
module spi_front
	import spi_front_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire logic                spi_sclk,
	input  wire logic                spi_ss_n,
	input  wire logic                spi_mosi_in,
	output logic                     spi_mosi_out,
	output logic                     spi_mosi_oe,
	output logic                     spi_miso,
	output logic                     spi_miso_oe,
	input  wire logic                full_duplex,
	input  wire logic [`BYTE_W-1:0]  usb_status,
	output logic                     host_mode,
	output logic                     ack_set,
	output logic                     rd_req,
	output logic [`IDX_W-1:0]        rd_index,
	input  wire logic [`BYTE_W-1:0]  rd_data,
	output logic                     wr_valid,
	input  wire logic                wr_ready,
	output logic [`IDX_W-1:0]        wr_index,
	output logic [`BYTE_W-1:0]       wr_data,
	output logic                     overrun,
	input  wire logic                overrun_clr
);

	front_state_t st;
	front_state_t next_st;
	logic         fifo_in_ready;
	wr_word_t     fifo_out;

	// Index walk: FIFO slots and index twenty freeze, the rest advance up to the last
	function automatic logic [`IDX_W-1:0] next_index(input logic [`IDX_W-1:0] idx);
		if (idx <= `IDX_FIFO_LAST || idx == `IDX_FROZEN_MID || idx == `IDX_LAST) begin
			return idx;
		end
		return idx + `IDX_W'(1);
	endfunction : next_index

	// Which indices the current mode exposes
	function automatic logic reg_present(input logic [`IDX_W-1:0] idx, input logic host);
		logic [31:0] mask;
		mask = host ? `HOST_REG_MASK : `PERIPH_REG_MASK;
		return mask[idx];
	endfunction : reg_present

	// Edges come from the second and third sync stages, never the first
	logic ss_active;
	logic ss_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic byte_done;
	logic [`BYTE_W-1:0] rx_byte;

	assign ss_active = !st.ss_s2;
	assign ss_fall   = !st.ss_s2 && st.ss_s3;
	assign sclk_rise = ss_active && st.sclk_s2 && !st.sclk_s3;
	assign sclk_fall = ss_active && !st.sclk_s2 && st.sclk_s3;
	assign rx_byte   = {st.rx[`BYTE_W-2:0], st.mosi_s2};
	assign byte_done = sclk_rise && (st.bit_cnt == `BIT_LAST);

	// Next-state logic for the whole front end
	always_comb begin
		next_st = st;
		next_st.ss_s1   = spi_ss_n;
		next_st.ss_s2   = st.ss_s1;
		next_st.ss_s3   = st.ss_s2;
		next_st.sclk_s1 = spi_sclk;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_s3 = st.sclk_s2;
		next_st.mosi_s1 = spi_mosi_in;
		next_st.mosi_s2 = st.mosi_s1;
		next_st.ack_set = 1'b0;
		next_st.rd_req  = 1'b0;
		next_st.push    = 1'b0;

		// Read answer arrives in the cycle the request stands; absent registers read zero
		if (st.rd_req) begin
			next_st.tx   = reg_present(st.rd_index, st.host) ? rd_data : '0;
			next_st.hold = 1'b1;
		end

		// Change output data on the falling edge; a freshly loaded byte keeps its top bit
		if (sclk_fall) begin
			if (st.hold) begin
				next_st.hold = 1'b0;
			end else begin
				next_st.tx = {st.tx[`BYTE_W-2:0], 1'b0};
			end
		end

		unique case (st.phase)
			PHASE_IDLE: begin
				if (ss_fall) begin
					next_st.phase   = PHASE_CMD;
					next_st.bit_cnt = '0;
					next_st.tx      = full_duplex ? usb_status : '0;
					next_st.hold    = 1'b0;
				end
			end
			PHASE_CMD: begin
				if (sclk_rise) begin
					next_st.rx      = rx_byte;
					next_st.bit_cnt = st.bit_cnt + 3'h1;
				end
				if (byte_done) begin
					next_st.phase = PHASE_DATA;
					next_st.index = rx_byte[`CMD_IDX_HI:`CMD_IDX_LO];
					next_st.dir   = rx_byte[`CMD_DIR_BIT];
					next_st.ack_set = rx_byte[`CMD_ACK_BIT] && !st.host;
					if (rx_byte[`CMD_DIR_BIT] == `DIR_READ) begin
						next_st.rd_req   = 1'b1;
						next_st.rd_index = rx_byte[`CMD_IDX_HI:`CMD_IDX_LO];
					end
				end
			end
			PHASE_DATA: begin
				if (sclk_rise) begin
					next_st.rx      = rx_byte;
					next_st.bit_cnt = st.bit_cnt + 3'h1;
				end
				if (byte_done) begin
					next_st.index = next_index(st.index);
					if (st.dir == `DIR_WRITE) begin
						// Writes to absent registers are dropped
						if (reg_present(st.index, st.host)) begin
							next_st.push      = 1'b1;
							next_st.push_word = '{index: st.index, data: rx_byte};
						end
						if (st.index == `ROLE_REG_IDX) begin
							next_st.host = rx_byte[`ROLE_HOST_BIT];
						end
					end else begin
						next_st.rd_req   = 1'b1;
						next_st.rd_index = next_index(st.index);
					end
				end
			end
			default: begin
				next_st.phase = PHASE_IDLE;
			end
		endcase

		// Select rising ends the frame whatever phase it is in
		if (st.ss_s2) begin
			next_st.phase = PHASE_IDLE;
		end

		// The serial master cannot stall, so a full FIFO loses the byte and flags it
		if (overrun_clr) begin
			next_st.overrun = 1'b0;
		end
		if (st.push && !fifo_in_ready) begin
			next_st.overrun = 1'b1;
		end

		// Pin drivers; half duplex leaves the data output released
		next_st.miso     = next_st.tx[`BYTE_W-1];
		next_st.mosi_out = next_st.tx[`BYTE_W-1];
		// Enables read the second sync stage only; the first may still be metastable
		next_st.miso_oe  = !st.ss_s2 && full_duplex;
		next_st.mosi_oe  = !st.ss_s2 && !full_duplex && next_st.phase == PHASE_DATA &&
			next_st.dir == `DIR_READ;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st       <= '0;
			st.ss_s1 <= 1'b1;
			st.ss_s2 <= 1'b1;
			st.ss_s3 <= 1'b1;
			st.host  <= `ROLE_HOST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Writes queue here so a slow register file does not hold up the link
	wr_fifo #(
		.WIDTH ($bits(wr_word_t)),
		.DEPTH (`FIFO_DEPTH)
	) u_wr_fifo (
		.mclk      (mclk),
		.srst      (srst),
		.in_valid  (st.push),
		.in_ready  (fifo_in_ready),
		.in_data   (st.push_word),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (fifo_out)
	);

	assign wr_index     = fifo_out.index;
	assign wr_data      = fifo_out.data;
	assign spi_mosi_out = st.mosi_out;
	assign spi_mosi_oe  = st.mosi_oe;
	assign spi_miso     = st.miso;
	assign spi_miso_oe  = st.miso_oe;
	assign host_mode    = st.host;
	assign ack_set      = st.ack_set;
	assign rd_req       = st.rd_req;
	assign rd_index     = st.rd_index;
	assign overrun      = st.overrun;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_cmd_done;
		st.phase == PHASE_CMD && byte_done;
	endsequence
	sequence s_rd_cmd;
		s_cmd_done ##0 rx_byte[`CMD_DIR_BIT] == `DIR_READ;
	endsequence

	a_ack_host_ignored : assert property (st.host |-> !ack_set)
		else $error("acknowledge raised in host mode");
	a_ack_peripheral : assert property (s_cmd_done ##0 (rx_byte[`CMD_ACK_BIT] && !st.host)
		|=> ack_set)
		else $error("acknowledge flag not forwarded");
	a_read_request : assert property (s_rd_cmd |=> rd_req &&
		rd_index == $past(rx_byte[`CMD_IDX_HI:`CMD_IDX_LO]))
		else $error("read request index wrong");
	a_index_freeze : assert property (st.phase == PHASE_DATA && byte_done &&
		(st.index <= `IDX_FIFO_LAST || st.index == `IDX_FROZEN_MID || st.index == `IDX_LAST)
		|=> st.index == $past(st.index))
		else $error("frozen index moved");
	a_index_step : assert property (st.phase == PHASE_DATA && byte_done &&
		st.index > `IDX_FIFO_LAST && st.index != `IDX_FROZEN_MID && st.index != `IDX_LAST
		|=> st.index == $past(st.index) + `IDX_W'(1))
		else $error("index did not advance by one");
	a_idle_released : assert property (st.ss_s2 |=> !spi_miso_oe && !spi_mosi_oe)
		else $error("pins driven while deselected");
	a_half_no_miso : assert property (!full_duplex |=> !spi_miso_oe)
		else $error("data output driven in half duplex");
	a_status_load : assert property (st.phase == PHASE_IDLE && ss_fall && full_duplex
		|=> st.tx == $past(usb_status) ##1 spi_miso == $past(st.tx[`BYTE_W-1]))
		else $error("status byte not presented");
	a_frame_restart : assert property (st.phase == PHASE_IDLE && ss_fall |=> st.bit_cnt == 3'h0)
		else $error("bit counter not restarted");
	a_role_reset : assert property ($fell(srst) |-> !host_mode)
		else $error("role not peripheral after reset");

endmodule : spi_front

//--- verif/spi_master_model.sv
// Serial master model for the front end's link, with the shared data line resolved
module spi_master_model (
	output logic      sclk,
	output logic      ss_n,
	output wire       mosi_line,
	input  wire logic miso,
	input  wire logic miso_oe,
	input  wire logic dut_out,
	input  wire logic dut_oe,
	input  wire logic fd
);
	timeunit 1ns;
	timeprecision 100ps;
	logic m_bit = 1'h0;
	logic m_oe  = 1'h0;

	// Clock idles low and stands still outside frames
	initial begin
		sclk = 1'h0;
		ss_n = 1'h1;
	end

	// A released line shows the inverse of the last bit, so a stale copy cannot pass
	assign mosi_line = dut_oe ? dut_out : (m_oe ? m_bit : ~m_bit);

	// Select edge, with a settle gap on each side
	task automatic sel(input logic lvl);
		#80 ss_n = lvl;
		#80;
	endtask : sel

	// Shift n bits, MSB first; change after falling, sample at rising
	task automatic xfer(input logic [7:0] tx, input logic drv, input int n, output logic [7:0] rx);
		for (int i = 7; i > 7 - n; i--) begin
			m_oe = drv;
			m_bit = tx[i];
			#80 sclk = 1'h1;
			rx[i] = fd ? (miso_oe ? miso : 1'hz) : mosi_line;
			#80 sclk = 1'h0;
		end
		m_oe = 1'h0;
	endtask : xfer
endmodule : spi_master_model

//--- verif/spi_front_tb_top.sv
// Self-checking bench for the serial register front end
module spi_front_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import spi_front_pkg::*;
	logic       mclk = 1'h0, srst = 1'h1, full_duplex = 1'h1, wr_ready = 1'h1, overrun_clr = 1'h0;
	logic [7:0] usb_status = 8'h00, rd_data, wr_data, st;
	logic [4:0] rd_index, wr_index;
	logic       sclk, ss_n, line, mo, mo_oe, miso, miso_oe, host_mode, ack_set, rd_req, wr_valid, overrun;
	int         n_fail = 0, n_tests = 0, n_ack = 0, bad_oe = 0, cyc = 0;
	logic [7:0] rb [8];
	wr_word_t   wq [$], eq [$];

	always #10 mclk = ~mclk;
	// Register file stand-in answers at once, so every read byte is predictable
	assign rd_data = {3'h5, rd_index};

	spi_front i_dut (.mclk(mclk), .srst(srst), .spi_sclk(sclk), .spi_ss_n(ss_n), .spi_mosi_in(line),
		.spi_mosi_out(mo), .spi_mosi_oe(mo_oe), .spi_miso(miso), .spi_miso_oe(miso_oe),
		.full_duplex(full_duplex), .usb_status(usb_status), .host_mode(host_mode), .ack_set(ack_set),
		.rd_req(rd_req), .rd_index(rd_index), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_index(wr_index), .wr_data(wr_data), .overrun(overrun), .overrun_clr(overrun_clr));
	spi_master_model i_mdl (.sclk(sclk), .ss_n(ss_n), .mosi_line(line), .miso(miso), .miso_oe(miso_oe),
		.dut_out(mo), .dut_oe(mo_oe), .fd(full_duplex));

	// Watchers: FIFO take-offs, acknowledge pulses, stray miso drive, hang limit
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (wr_valid && wr_ready)
			wq.push_back({wr_index, wr_data});
		if (ack_set)
			n_ack <= n_ack + 1;
		if (!full_duplex && miso_oe)
			bad_oe <= bad_oe + 1;
		if (cyc == 20000) begin
			n_fail++;
			$display("MISMATCH %0t timeout", $time);
			test_done();
		end
	end

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, input logic exp, input string msg);
		chk_byte({7'h00, got}, {7'h00, exp}, msg);
	endtask : chk_bit

	task automatic ew(input logic [4:0] i, input logic [7:0] d);
		eq.push_back({i, d});
	endtask : ew

	// Compare taken writes against the expected list, in order
	task automatic chk_q;
		repeat (30) @(posedge mclk);
		chk_byte(8'(wq.size()), 8'(eq.size()), "write count");
		while (eq.size() > 0 && wq.size() > 0) begin
			chk_byte({3'h0, wq[0].index}, {3'h0, eq[0].index}, "write index");
			chk_byte(wq[0].data, eq[0].data, "write data");
			void'(wq.pop_front());
			void'(eq.pop_front());
		end
		wq.delete();
		eq.delete();
	endtask : chk_q

	// One framed access: command byte, then nb data bytes counting up from d0
	task automatic access(input logic [4:0] idx, input logic dir, input logic ack, input int nb, input logic [7:0] d0);
		logic [7:0] r;
		@(posedge mclk) #7;
		i_mdl.sel(1'h0);
		i_mdl.xfer({idx, 1'h0, dir, ack}, 1'h1, 8, st);
		for (int k = 0; k < nb; k++) begin
			i_mdl.xfer(d0 + 8'(k), dir, 8, r);
			rb[k] = r;
		end
		i_mdl.sel(1'h1);
		repeat (6) @(posedge mclk);
	endtask : access

	task automatic t_status;
		@(posedge mclk) usb_status <= 8'hA5;
		access(5'h05, 1'h1, 1'h0, 3, 8'h10);
		chk_byte(st, 8'hA5, "status byte");
		chk_bit(miso_oe, 1'h0, "miso released");
		ew(5'h05, 8'h10);
		ew(5'h06, 8'h11);
		ew(5'h07, 8'h12);
		chk_q();
	endtask : t_status

	task automatic t_walk;
		access(5'h03, 1'h1, 1'h0, 2, 8'h20);
		access(5'h13, 1'h1, 1'h0, 3, 8'h30);
		access(5'h18, 1'h1, 1'h0, 2, 8'h40);
		ew(5'h03, 8'h20);
		ew(5'h03, 8'h21);
		ew(5'h13, 8'h30);
		ew(5'h14, 8'h31);
		ew(5'h14, 8'h32);
		ew(5'h18, 8'h40);
		chk_q();
	endtask : t_walk

	// Stalled register file: eight bytes fit, the rest are lost and flagged
	task automatic t_fill;
		@(posedge mclk) wr_ready <= 1'h0;
		access(5'h00, 1'h1, 1'h0, 10, 8'h50);
		chk_bit(overrun, 1'h1, "overrun set");
		for (int k = 0; k < 8; k++)
			ew(5'h00, 8'h50 + 8'(k));
		@(posedge mclk) wr_ready <= 1'h1;
		chk_q();
		@(posedge mclk) overrun_clr <= 1'h1;
		@(posedge mclk) overrun_clr <= 1'h0;
		repeat (2) @(posedge mclk);
		chk_bit(overrun, 1'h0, "overrun cleared");
	endtask : t_fill

	task automatic t_read;
		@(posedge mclk) full_duplex <= 1'h0;
		access(5'h05, 1'h0, 1'h0, 3, 8'h00);
		chk_byte(rb[0], 8'hA5, "read 5");
		chk_byte(rb[2], 8'hA7, "read 7");
		access(5'h18, 1'h0, 1'h0, 2, 8'h00);
		chk_byte(rb[0], 8'hB8, "read 24");
		chk_byte(rb[1], 8'h00, "read 25 absent");
		access(5'h09, 1'h0, 1'h1, 0, 8'h00);
		chk_byte(8'(n_ack), 8'h01, "ack count");
		chk_byte(8'(bad_oe), 8'h00, "miso idle half duplex");
		@(posedge mclk) full_duplex <= 1'h1;
	endtask : t_read

	task automatic t_host;
		access(5'h1B, 1'h1, 1'h0, 1, 8'h01);
		chk_bit(host_mode, 1'h1, "host set");
		access(5'h1E, 1'h1, 1'h1, 3, 8'h60);
		ew(5'h1B, 8'h01);
		ew(5'h1E, 8'h60);
		ew(5'h1F, 8'h61);
		ew(5'h1F, 8'h62);
		chk_q();
		chk_byte(8'(n_ack), 8'h01, "ack ignored");
		access(5'h05, 1'h0, 1'h0, 1, 8'h00);
		chk_byte(rb[0], 8'h00, "host absent");
		@(posedge mclk) srst <= 1'h1;
		repeat (4) @(posedge mclk);
		srst <= 1'h0;
		repeat (6) @(posedge mclk);
		chk_bit(host_mode, 1'h0, "role reset");
	endtask : t_host

	// A command cut short by select must not shift the next frame
	task automatic t_abort;
		@(posedge mclk) #7;
		i_mdl.sel(1'h0);
		i_mdl.xfer(8'hFF, 1'h1, 4, st);
		i_mdl.sel(1'h1);
		access(5'h06, 1'h1, 1'h0, 1, 8'h77);
		ew(5'h06, 8'h77);
		chk_q();
	endtask : t_abort

	initial begin
		repeat (4) @(posedge mclk);
		srst <= 1'h0;
		repeat (6) @(posedge mclk);
		t_status();
		t_walk();
		t_fill();
		t_read();
		t_host();
		t_abort();
		test_done();
	end
endmodule : spi_front_tb_top
